// ### logic/mcs_pkg.sv
// Package: register map, field layout and sizes of the MAC control block
package mcs_pkg;

  // ==========================================================
  // Sizes
  // ==========================================================
  localparam int ACC_W     = 40;
  localparam int BYTE_W    = 8;
  localparam int ACC_BYTES = 5;
  localparam int ADDR_W    = 12;
  localparam int IDX_W     = 10;
  localparam int DATA_W    = 32;
  localparam int SHIFT_W   = 3;
  localparam int IRQ_W     = 2;

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [IDX_W-1:0] IDX_CTRL    = 10'h0E7;
  localparam logic [IDX_W-1:0] IDX_ACC0    = 10'h0E8;
  localparam logic [IDX_W-1:0] IDX_ACC4    = 10'h0EC;
  localparam logic [IDX_W-1:0] IDX_IRQ_ST  = 10'h0F0;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN  = 10'h0F1;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 10'h0F2;

  // ==========================================================
  // Control register fields
  // ==========================================================
  localparam int CTRL_IE_BIT   = 7;
  localparam int CTRL_FILL_BIT = 6;
  localparam int OUT_SH_LSB    = 3;
  localparam int IN_SH_LSB     = 0;
  localparam logic [BYTE_W-1:0] CTRL_RESET = 8'h00;

  // ==========================================================
  // Interrupt status bits and reset values
  // ==========================================================
  localparam int IRQ_DONE_IE  = 0;
  localparam int IRQ_DONE_ANY = 1;
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 2'h1;
  localparam logic [IRQ_W-1:0] IRQ_ST_RESET = 2'h0;

endpackage : mcs_pkg

// ### logic/mcs_shifter.sv
// Shift network: signed read view and filled write view of the accumulator
`timescale 1ns/1ps

module mcs_shifter
#(
  parameter int ACC_W   = mcs_pkg::ACC_W,
  parameter int SHIFT_W = mcs_pkg::SHIFT_W
)
(
  input  wire logic [ACC_W-1:0]   accValue,
  input  wire logic [SHIFT_W-1:0] outShift,
  input  wire logic [ACC_W-1:0]   stageValue,
  input  wire logic [SHIFT_W-1:0] inShift,
  input  wire logic               fill,
  output logic      [ACC_W-1:0]   readView,
  output logic      [ACC_W-1:0]   writeView
);

  logic [ACC_W-1:0] fillMask;

  // ==========================================================
  // Read side
  // ==========================================================
  // Arithmetic shift copies bit 39 into every vacated top bit
  always_comb
  begin
    readView = ACC_W'($signed(accValue) >>> outShift); // RULE_05 RULE_06
  end

  // ==========================================================
  // Write side
  // ==========================================================
  // Low bits vacated by the shift all take the fill level
  always_comb
  begin
    fillMask  = ACC_W'((ACC_W'(1) << inShift) - ACC_W'(1));
    writeView = (stageValue << inShift)
              | (fill ? fillMask : '0); // RULE_04 RULE_07 RULE_08
  end

endmodule : mcs_shifter

// ### logic/mcs_mac_control.sv
// MAC control register, shifted accumulator access and done interrupt
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps

// Behaviour
// (RULE_01) Any control register write zeroes all 40 accumulator bits.
// (RULE_02) Enable bit 7 set: raise interrupt request when calculation done.
// (RULE_03) Enable bit is captured for the calculation being set up.
// (RULE_04) Fill bit 6 supplies every low bit vacated by a write shift.
// (RULE_05) Read shift 000 returns accumulator bytes unshifted.
// (RULE_06) Read shift N returns accumulator shifted right N, sign-filled.
// (RULE_07) Write shift 000 stores the written 40-bit value unshifted.
// (RULE_08) Write shift N stores value shifted left N, low bits filled.
// (RULE_09) Accumulator is five byte registers, lowest offset holds bits 7:0.
// (RULE_10) Read shift changes only returned data, never stored contents.
module mcs_mac_control
(
  input  wire logic                         core_clk,
  input  wire logic                         nrst,
  input  wire logic [mcs_pkg::ADDR_W-1:0]   address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [mcs_pkg::DATA_W-1:0]   writedata,
  output logic      [mcs_pkg::DATA_W-1:0]   readdata,
  output logic                              waitrequest,
  input  wire logic                         calcDone,
  input  wire logic                         engineLoad,
  input  wire logic [mcs_pkg::ACC_W-1:0]    engineAcc,
  output logic      [mcs_pkg::ACC_W-1:0]    accumulator,
  output logic                              calcIrqEnable,
  output logic                              irq
);

  // ==========================================================
  // Declarations
  // ==========================================================
  localparam int AW = mcs_pkg::ACC_W;
  localparam int BW = mcs_pkg::BYTE_W;
  localparam int NB = mcs_pkg::ACC_BYTES;
  localparam int IW = mcs_pkg::IDX_W;
  localparam int SW = mcs_pkg::SHIFT_W;
  localparam int QW = mcs_pkg::IRQ_W;

  logic [BW-1:0] macControl;
  logic [BW-1:0] stage [NB-1];
  logic [AW-1:0] stageFull;
  logic [AW-1:0] readView;
  logic [AW-1:0] writeView;
  logic [QW-1:0] irqStatus;
  logic [QW-1:0] irqEnable;
  logic [IW-1:0] regIdx;
  logic          served;
  logic          request;
  logic          wrTake;
  logic          ctrlWrite;
  logic          accCommit;
  logic          clrWrite;
  logic [SW-1:0] outShift;
  logic [SW-1:0] inShift;
  logic          fill;
  logic [QW-1:0] next_status;
  logic [QW-1:0] next_enable;
  logic [mcs_pkg::DATA_W-1:0] next_readdata;

  // ==========================================================
  // Decode helpers
  // ==========================================================
  // Accumulator byte window check, used by read and write paths
  function automatic logic isAccByte(input logic [IW-1:0] idx);
    isAccByte = (idx >= mcs_pkg::IDX_ACC0)
             && (idx <= mcs_pkg::IDX_ACC4);
  endfunction : isAccByte

  // Byte number inside the accumulator, lowest offset first
  function automatic logic [2:0] accByteNum(input logic [IW-1:0] idx);
    logic [IW-1:0] diff;
    diff       = idx - mcs_pkg::IDX_ACC0;
    accByteNum = diff[2:0];
  endfunction : accByteNum

  // ==========================================================
  // Field views of the control register
  // ==========================================================
  assign outShift = macControl[mcs_pkg::OUT_SH_LSB +: SW];
  assign inShift  = macControl[mcs_pkg::IN_SH_LSB +: SW];
  assign fill     = macControl[mcs_pkg::CTRL_FILL_BIT];
  assign regIdx   = address[mcs_pkg::ADDR_W-1:2];

  // ==========================================================
  // Avalon-MM handshake
  // ==========================================================
  // One wait state: the request is decoded in the first cycle,
  // answered in the second, so read data come from a flip-flop
  assign request     = read || write;
  assign waitrequest = request && !served;
  assign wrTake      = write && served;
  assign ctrlWrite   = wrTake && (regIdx == mcs_pkg::IDX_CTRL);
  assign accCommit   = wrTake && (regIdx == mcs_pkg::IDX_ACC4);
  assign clrWrite    = wrTake && (regIdx == mcs_pkg::IDX_IRQ_CLR);

  // Served flag pulses for the single answering cycle
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      served <= 1'b0;
    else
      served <= request && !served;
  end

  // ==========================================================
  // Control register
  // ==========================================================
  // Plain read/write byte, steering shifts, fill and enable
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      macControl <= mcs_pkg::CTRL_RESET;
    else if (ctrlWrite)
      macControl <= writedata[BW-1:0];
  end

  // Enable latched per calculation; later engine work keeps it
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      calcIrqEnable <= 1'b0;
    else if (ctrlWrite)
      calcIrqEnable <= writedata[mcs_pkg::CTRL_IE_BIT]; // RULE_03
  end

  // ==========================================================
  // Write staging of the lower accumulator bytes
  // ==========================================================
  // Bytes 0 to 3 wait here so the shift sees one 40-bit value,
  // committed by the write of the top byte
  generate
    for (genvar b = 0; b < NB - 1; b++)
    begin : g_stage
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
          stage[b] <= '0;
        else if (wrTake && isAccByte(regIdx)
                 && accByteNum(regIdx) == 3'(b))
          stage[b] <= writedata[BW-1:0]; // RULE_09
      end
    end
  endgenerate

  // Top byte joins the staged bytes in the commit cycle
  assign stageFull = {writedata[BW-1:0], stage[3], stage[2],
                      stage[1], stage[0]}; // RULE_09

  // ==========================================================
  // Shift network
  // ==========================================================
  mcs_shifter
  #(
    .ACC_W   (AW),
    .SHIFT_W (SW)
  )
  u_shifter
  (
    .accValue   (accumulator),
    .outShift   (outShift),
    .stageValue (stageFull),
    .inShift    (inShift),
    .fill       (fill),
    .readView   (readView),
    .writeView  (writeView)
  );

  // ==========================================================
  // Accumulator
  // ==========================================================
  // Control write beats the CPU commit, which beats the engine;
  // reads never touch it, the shift lives only in the read view
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      accumulator <= '0;
    else if (ctrlWrite)
      accumulator <= '0; // RULE_01
    else if (accCommit)
      accumulator <= writeView; // RULE_07 RULE_08
    else if (engineLoad)
      accumulator <= engineAcc; // RULE_10
  end

  // ==========================================================
  // Interrupt status, enable and clear
  // ==========================================================
  // Hardware set wins over a clear in the same cycle
  always_comb
  begin
    next_status = irqStatus;
    if (clrWrite)
      next_status = next_status & ~writedata[QW-1:0];
    if (calcDone && calcIrqEnable)
      next_status[mcs_pkg::IRQ_DONE_IE] = 1'b1; // RULE_02
    if (calcDone)
      next_status[mcs_pkg::IRQ_DONE_ANY] = 1'b1;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      irqStatus <= mcs_pkg::IRQ_ST_RESET;
    else
      irqStatus <= next_status;
  end

  // Next enable seen by the line too, so an enable write acts at once
  always_comb
  begin
    next_enable = irqEnable;
    if (wrTake && regIdx == mcs_pkg::IDX_IRQ_EN)
      next_enable = writedata[QW-1:0];
  end

  // Enable resets with the done bit open so bit 7 alone suffices
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      irqEnable <= mcs_pkg::IRQ_EN_RESET;
    else
      irqEnable <= next_enable;
  end

  // Level request while any enabled status bit stands
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(next_status & next_enable); // RULE_02
  end

  // ==========================================================
  // Read data
  // ==========================================================
  // Unmapped and write-only offsets read as zero
  always_comb
  begin
    next_readdata = '0;
    if (isAccByte(regIdx))
      next_readdata[BW-1:0] =
        readView[accByteNum(regIdx)*BW +: BW]; // RULE_05 RULE_06
    else if (regIdx == mcs_pkg::IDX_CTRL)
      next_readdata[BW-1:0] = macControl;
    else if (regIdx == mcs_pkg::IDX_IRQ_ST)
      next_readdata[QW-1:0] = irqStatus;
    else if (regIdx == mcs_pkg::IDX_IRQ_EN)
      next_readdata[QW-1:0] = irqEnable;
  end

  // Captured in the decode cycle, stands through the answer
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      readdata <= '0;
    else if (read && !served)
      readdata <= next_readdata;
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_ctl_clears_acc: assert property ( // RULE_01
    ctrlWrite |=> accumulator == '0)
    else $error("Control write did not clear accumulator");

  a_irq_raised: assert property ( // RULE_02
    calcDone && calcIrqEnable && next_enable[mcs_pkg::IRQ_DONE_IE]
    |=> irq)
    else $error("Done with enable did not raise interrupt");

  a_irq_mirrors: assert property ( // RULE_02
    irq == |(irqStatus & irqEnable))
    else $error("Interrupt line differs from enabled status");

  a_set_wins: assert property ( // RULE_02
    clrWrite && calcDone |=> irqStatus[mcs_pkg::IRQ_DONE_ANY])
    else $error("Clear in the done cycle dropped the done flag");

  a_irq_quiet: assert property ( // RULE_02
    calcDone && !calcIrqEnable
    && !irqStatus[mcs_pkg::IRQ_DONE_IE]
    |=> !irqStatus[mcs_pkg::IRQ_DONE_IE])
    else $error("Done without enable set the done flag");

  a_ie_captured: assert property ( // RULE_03
    ctrlWrite |=> calcIrqEnable
      == $past(writedata[mcs_pkg::CTRL_IE_BIT]))
    else $error("Interrupt enable not captured on control write");

  a_fill_low_bit: assert property ( // RULE_04
    accCommit && inShift != 3'h0
    |=> accumulator[0] == $past(fill))
    else $error("Low bit after shifted write is not the fill");

  a_read_plain: assert property ( // RULE_05
    read && served && regIdx == mcs_pkg::IDX_ACC0
    && outShift == 3'h0 && !$past(engineLoad)
    |-> readdata[BW-1:0] == accumulator[BW-1:0])
    else $error("Unshifted read differs from accumulator");

  a_read_sign: assert property ( // RULE_06
    read && served && regIdx == mcs_pkg::IDX_ACC4
    && outShift != 3'h0
    |-> readdata[BW-1] == $past(accumulator[AW-1]))
    else $error("Shifted read top bit is not the sign");

  a_read_shift1: assert property ( // RULE_06
    read && served && regIdx == mcs_pkg::IDX_ACC0
    && outShift == 3'h1 && !$past(engineLoad)
    |-> readdata[BW-1:0] == accumulator[BW:1])
    else $error("Read shift by one returned wrong bits");

  a_write_plain: assert property ( // RULE_07
    accCommit && inShift == 3'h0
    |=> accumulator == $past(stageFull))
    else $error("Unshifted write stored a changed value");

  a_write_shift1: assert property ( // RULE_08
    accCommit && inShift == 3'h1
    |=> accumulator[AW-1:1] == $past(stageFull[AW-2:0]))
    else $error("Write shift by one stored wrong bits");

  a_write_shift7: assert property ( // RULE_08
    accCommit && inShift == 3'h7
    |=> accumulator == {$past(stageFull[AW-8:0]), {7{$past(fill)}}})
    else $error("Write shift by seven stored wrong bits");

  a_top_byte: assert property ( // RULE_09
    accCommit && inShift == 3'h0
    |=> accumulator[AW-1:AW-BW] == $past(writedata[BW-1:0]))
    else $error("Top byte write landed in wrong bits");

  a_read_keeps: assert property ( // RULE_10
    read && !ctrlWrite && !accCommit && !engineLoad
    |=> accumulator == $past(accumulator))
    else $error("Read altered the stored accumulator");

  c_shift_read: cover property (
    read && served && isAccByte(regIdx) && outShift == 3'h7);
  c_shift_write: cover property (
    accCommit && inShift == 3'h7 && fill);
  c_irq_fire: cover property (calcDone && calcIrqEnable ##2 irq);
  c_clear_race: cover property (clrWrite && calcDone);

endmodule : mcs_mac_control

// ### verif/mcs_engine_model.sv
// Engine stand-in: loads an accumulator value, then pulses done
`timescale 1ns/1ps

module mcs_engine_model
(
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  input  wire logic                      go,
  input  wire logic [7:0]                doneDelay,
  input  wire logic [mcs_pkg::ACC_W-1:0] goValue,
  output logic                           calcDone,
  output logic                           engineLoad,
  output logic      [mcs_pkg::ACC_W-1:0] engineAcc
);
  logic [7:0] count;
  logic       busy;

  // ==========================================================
  // Sequencer
  // ==========================================================
  // Idle value bus toggles so a stale value never looks like a load
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy       <= 1'b0;
      count      <= 8'h00;
      calcDone   <= 1'b0;
      engineLoad <= 1'b0;
      engineAcc  <= 40'h00_0000_0000;
    end
    else
    begin
      engineLoad <= go;
      calcDone   <= busy && (count == 8'h00);
      engineAcc  <= go ? goValue : ~engineAcc;
      if (go)
      begin
        busy  <= 1'b1;
        count <= doneDelay; // Zero answers promptly, large is slow
      end
      else if (busy && count == 8'h00)
        busy <= 1'b0;
      else if (busy)
        count <= count - 8'h01;
    end
  end
endmodule : mcs_engine_model

// ### verif/test_mac_control_and_shift.sv
// Self-checking bench for the MAC control and shift block
`timescale 1ns/1ps

module test_mac_control_and_shift;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [11:0] address = 12'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        calcDone;
  logic        engineLoad;
  logic [39:0] engineAcc;
  logic [39:0] accumulator;
  logic        calcIrqEnable;
  logic        irq;
  logic        go = 1'b0;
  logic [7:0]  doneDelay = 8'h00;
  logic [39:0] goValue = 40'h0;
  logic [31:0] seed = 32'h2020C4A9;
  logic [31:0] q;
  logic [39:0] dIn;
  logic [39:0] accExp;
  logic [39:0] got;
  logic [7:0]  ctl;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;

  mcs_mac_control u_dut (.core_clk(core_clk), .nrst(nrst),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .calcDone(calcDone),
    .engineLoad(engineLoad), .engineAcc(engineAcc),
    .accumulator(accumulator), .calcIrqEnable(calcIrqEnable), .irq(irq));

  mcs_engine_model u_engine (.core_clk(core_clk), .nrst(nrst), .go(go),
    .doneDelay(doneDelay), .goValue(goValue), .calcDone(calcDone),
    .engineLoad(engineLoad), .engineAcc(engineAcc));

  // ==========================================================
  // Clock and timeout
  // ==========================================================
  always #5 core_clk = ~core_clk;

  // Whole run needs a few thousand cycles; ceiling leaves margin
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done();
    end
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Expected stored value after a shifted CPU write
  function automatic logic [39:0] lsh(input logic [39:0] d,
                                      input int n, input logic f);
    return (d << n) | (f ? ((40'h1 << n) - 40'h1) : 40'h0);
  endfunction : lsh

  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Avalon access: request held until waitrequest is seen low at a
  // rising edge; that edge lands the write and takes the read data
  task automatic bus(input logic wr, input logic [9:0] idx,
                     input logic [31:0] d);
    address   <= {idx, 2'b00};
    read      <= !wr;
    write     <= wr;
    writedata <= d;
    @(posedge core_clk);
    while (waitrequest !== 1'b0)
      @(posedge core_clk);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge core_clk); // Idle edge keeps the next request apart
  endtask : bus

  // Start a calculation and wait, bounded, for its done pulse
  task automatic calc(input logic [7:0] dly);
    int n;
    n = 0;
    seed = xs(seed);
    goValue   <= {seed[7:0], seed};
    doneDelay <= dly;
    go        <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    while (calcDone !== 1'b1 && n < 300)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(calcDone, 1'b1); // Engine must finish inside the limit
    repeat (2) @(posedge core_clk);
  endtask : calc

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, mcs_pkg::IDX_CTRL, 32'h0);
    chk(q, 40'h0);
    bus(1'b0, mcs_pkg::IDX_IRQ_EN, 32'h0);
    chk(q, 40'h1);
    bus(1'b0, 10'h0FF, 32'h0);
    chk(q, 40'h0);
    chk(accumulator, 40'h0);
    $display("Test reset values done");

    // Every shift code on both fields, then random mixes
    for (int i = 0; i < 16; i++)
    begin
      seed = xs(seed);
      ctl = (i < 8) ? {seed[7:6], 3'(7 - i), 3'(i)} : seed[7:0];
      calc(seed[15:8]);
      chk(accumulator, goValue);
      bus(1'b1, mcs_pkg::IDX_CTRL, {24'h0, ctl});
      chk(accumulator, 40'h0);
      chk(calcIrqEnable, ctl[7]);
      bus(1'b0, mcs_pkg::IDX_CTRL, 32'h0);
      chk(q[7:0], ctl);
      seed = xs(seed);
      dIn = {i[0], seed[6:0], xs(seed)};
      for (int k = 0; k < 5; k++)
        bus(1'b1, mcs_pkg::IDX_ACC0 + 10'(k), {24'h0, dIn[8*k +: 8]});
      accExp = lsh(dIn, int'(ctl[2:0]), ctl[6]);
      chk(accumulator, accExp);
      for (int k = 0; k < 5; k++)
      begin
        bus(1'b0, mcs_pkg::IDX_ACC0 + 10'(k), 32'h0);
        got[8*k +: 8] = q[7:0];
      end
      chk(got, $signed(accExp) >>> ctl[5:3]);
      chk(accumulator, accExp);
    end
    $display("Test shifted access done");

    // Done interrupt: enabled, disabled, masked, cleared
    bus(1'b1, mcs_pkg::IDX_IRQ_CLR, 32'h3);
    bus(1'b1, mcs_pkg::IDX_CTRL, 32'h80);
    calc(8'h00);
    chk(irq, 1'b1);
    bus(1'b0, mcs_pkg::IDX_IRQ_ST, 32'h0);
    chk(q, 40'h3);
    bus(1'b1, mcs_pkg::IDX_IRQ_CLR, 32'h3);
    chk(irq, 1'b0);
    bus(1'b1, mcs_pkg::IDX_CTRL, 32'h00);
    calc(8'h05);
    chk(irq, 1'b0);
    bus(1'b0, mcs_pkg::IDX_IRQ_ST, 32'h0);
    chk(q, 40'h2);
    bus(1'b1, mcs_pkg::IDX_IRQ_EN, 32'h0);
    bus(1'b1, mcs_pkg::IDX_IRQ_CLR, 32'h3);
    bus(1'b1, mcs_pkg::IDX_CTRL, 32'h80);
    calc(8'h02);
    chk(irq, 1'b0);
    bus(1'b1, mcs_pkg::IDX_IRQ_EN, 32'h1);
    chk(irq, 1'b1);
    // Clear lands in the same cycle as a done pulse: the set must win
    fork
      calc(8'h00);
      begin
        @(posedge core_clk);
        bus(1'b1, mcs_pkg::IDX_IRQ_CLR, 32'h3);
      end
    join
    bus(1'b0, mcs_pkg::IDX_IRQ_ST, 32'h0);
    chk(q, 40'h3);
    bus(1'b0, mcs_pkg::IDX_IRQ_CLR, 32'h0);
    chk(q, 40'h0);
    $display("Test done interrupt done");
    test_done();
  end
endmodule : test_mac_control_and_shift
